// *** hdl/sc_consts.svh ***
`ifndef SC_CONSTS_SVH
`define SC_CONSTS_SVH

// ****************************************************
// Clock and timing
// ****************************************************
`define SC_CLK_HZ          125000000
`define SC_MS_CYCLES       125000
`define SC_RESET_MS        298
`define SC_POWERUP_MS      970
`define SC_PON_BEEP_MS     400
`define SC_PON_BEEP_HZ     4184
`define SC_GR_BEEP_MS      80
`define SC_GR_BEEP_HZ      2730
`define SC_GR_LED_MS       20
`define SC_LEVEL_TRIG_MS   10
`define SC_PULSE_TRIG_MS   50
`define SC_SESSION_TO_MS   3000

// ****************************************************
// Register offsets
// ****************************************************
`define SC_CTRL_OFS        12'h000
`define SC_TONE_HP_OFS     12'h004
`define SC_TONE_DUR_OFS    12'h008
`define SC_LED_DUR_OFS     12'h00C
`define SC_TIMEOUT_OFS     12'h010
`define SC_CMD_OFS         12'h014
`define SC_STATUS_OFS      12'h018

// ****************************************************
// Field positions
// ****************************************************
`define SC_CTRL_IFSEL      0
`define SC_CTRL_PON_BEEP   1
`define SC_CTRL_GR_BEEP    2
`define SC_CTRL_GR_LED     3
`define SC_CTRL_PULSE      4
`define SC_CMD_GOOD_READ   0
`define SC_CMD_ABORT       1

// ****************************************************
// Reset values
// ****************************************************
`define SC_CTRL_RST        5'h0F
`define SC_TIMEOUT_RST     16'h0BB8

`endif

// *** hdl/sc_host_signals.sv ***
// Overview of operation
// - After reset the block waits 298ms in reset, boots, and accepts commands only after 970ms.
// - The flat-cable port is serial when iface_select is high and USB when it is low.
// - The auxiliary connector is only ever a USB port, never serial.
// - Serial mode drives transmit data and active-low request-to-send, takes receive and clear-to-send shared with USB.
// - If enabled, a fixed 4184Hz tone of 400ms sounds on the buzzer 970ms after power-on.
// - If enabled, each good read sounds a tone, 80ms at 2730Hz by default, both programmable.
// - If enabled, each good read pulls the LED low for a programmable time, 20ms by default.
// - Buzzer and LED outputs are open-drain, active when pulled low.
// - In level mode a trigger held low over 10ms starts a session that runs until decode, release or session timeout.
// - In pulse mode any low pulse of 10ms or more, not only one near 50ms, starts scanning at release until decode or session timeout.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "sc_consts.svh"
module sc_host_signals #(
  parameter int MS_CYCLES  = `SC_MS_CYCLES,
  parameter int PON_HP_CYC = `SC_CLK_HZ / (2 * `SC_PON_BEEP_HZ),
  parameter int GR_HP_CYC  = `SC_CLK_HZ / (2 * `SC_GR_BEEP_HZ)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        scan_trigger_n,
  input  wire logic        core_txd,
  input  wire logic        core_rts_n,
  output logic             core_rxd,
  output logic             core_cts_n,
  input  wire logic        fpc_rxd_dm,
  input  wire logic        fpc_cts_dp,
  output logic             fpc_txd,
  output logic             fpc_rts_n,
  output logic             fpc_usb_en,
  output logic             aux_usb_en,
  output logic             iface_select,
  output logic             cmd_ready,
  output logic             scan_active,
  input  wire logic        buzzer_out_n_in,
  output logic             buzzer_out_n,
  output logic             buzzer_out_n_oe,
  input  wire logic        read_ok_led_n_in,
  output logic             read_ok_led_n,
  output logic             read_ok_led_n_oe
);

  // ****************************************************
  // Helpers and state
  // ****************************************************
  function automatic logic [15:0] ms16(input int v);
    ms16 = v[15:0];
  endfunction

  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

  logic [16:0]      div_reg;
  logic             tick_reg;
  logic [15:0]      pu_ms_reg;
  sc_pkg::sc_pu_t   pu_reg;
  logic             pon_pend_reg;
  sc_pkg::sc_trig_t tr_reg;
  logic [15:0]      tr_ms_reg;
  logic [4:0]       ctrl_reg;
  logic [15:0]      hp_reg;
  logic [15:0]      dur_reg;
  logic [15:0]      led_dur_reg;
  logic [15:0]      led_ms_reg;
  logic             led_on_reg;
  logic [15:0]      to_reg;
  logic             good_read;
  logic             abort_cmd;
  logic             wr_en;
  logic             tone_go;
  logic             tone_pon;
  logic             ready;

  sc_tone_if tif ();

  assign ready = (pu_reg == sc_pkg::SC_PU_READY);

  // ****************************************************
  // Millisecond enable
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n || div_reg == MS_LAST) begin
      div_reg  <= 17'h00000;
      tick_reg <= rst_n;
    end else begin
      div_reg  <= div_reg + 17'h00001;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************************
  // Power-up sequence
  // ****************************************************
  // reset then boot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pu_reg    <= sc_pkg::SC_PU_RESET;
      pu_ms_reg <= 16'h0000;
    end else if (tick_reg && !ready) begin
      pu_ms_reg <= pu_ms_reg + 16'h0001;
      if (pu_ms_reg + 16'h0001 >= ms16(`SC_POWERUP_MS))
        pu_reg <= sc_pkg::SC_PU_READY;
      else if (pu_ms_reg + 16'h0001 >= ms16(`SC_RESET_MS))
        pu_reg <= sc_pkg::SC_PU_BOOT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      pon_pend_reg <= 1'b1;
    else if (ready)
      pon_pend_reg <= 1'b0;
  end

  // ****************************************************
  // APB slave
  // ****************************************************
  assign wr_en     = psel && penable && pready && pwrite;
  assign good_read = wr_en && ready && paddr == `SC_CMD_OFS && pwdata[`SC_CMD_GOOD_READ];
  assign abort_cmd = wr_en && ready && paddr == `SC_CMD_OFS && pwdata[`SC_CMD_ABORT];

  // Zero-wait answer in the access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= 1'b0;
      if (psel && !penable && !pready) begin
        prdata <= 32'h00000000;
        case (paddr)
          `SC_CTRL_OFS:     prdata <= {27'h0, ctrl_reg};
          `SC_TONE_HP_OFS:  prdata <= {16'h0000, hp_reg};
          `SC_TONE_DUR_OFS: prdata <= {16'h0000, dur_reg};
          `SC_LED_DUR_OFS:  prdata <= {16'h0000, led_dur_reg};
          `SC_TIMEOUT_OFS:  prdata <= {16'h0000, to_reg};
          `SC_CMD_OFS:      prdata <= 32'h00000000;
          `SC_STATUS_OFS:   prdata <= {25'h0, !read_ok_led_n_in, !buzzer_out_n_in,
                                       tr_reg, led_on_reg, tif.busy, ready};
          default:          pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg    <= `SC_CTRL_RST;
      hp_reg      <= GR_HP_CYC[15:0];
      dur_reg     <= ms16(`SC_GR_BEEP_MS);
      led_dur_reg <= ms16(`SC_GR_LED_MS);
      to_reg      <= `SC_TIMEOUT_RST;
    end else if (wr_en) begin
      case (paddr)
        `SC_CTRL_OFS:     ctrl_reg    <= pwdata[4:0];
        `SC_TONE_HP_OFS:  hp_reg      <= pwdata[15:0];
        `SC_TONE_DUR_OFS: dur_reg     <= pwdata[15:0];
        `SC_LED_DUR_OFS:  led_dur_reg <= pwdata[15:0];
        `SC_TIMEOUT_OFS:  to_reg      <= pwdata[15:0];
        default:          ;
      endcase
    end
  end

  // ****************************************************
  // Trigger and decode session
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tr_reg    <= sc_pkg::SC_TR_IDLE;
      tr_ms_reg <= 16'h0000;
    end else begin
      if (tick_reg)
        tr_ms_reg <= tr_ms_reg + 16'h0001;
      case (tr_reg)
        sc_pkg::SC_TR_IDLE: begin
          tr_ms_reg <= 16'h0000;
          if (ready && !scan_trigger_n)
            tr_reg <= sc_pkg::SC_TR_LOW;
        end
        sc_pkg::SC_TR_LOW: begin
          // level mode needs over 10ms low
          if (!ctrl_reg[`SC_CTRL_PULSE] && !scan_trigger_n
              && tr_ms_reg > ms16(`SC_LEVEL_TRIG_MS)) begin
            tr_reg    <= sc_pkg::SC_TR_SCAN;
            tr_ms_reg <= 16'h0000;
          end else if (ctrl_reg[`SC_CTRL_PULSE] && scan_trigger_n
                       && tr_ms_reg >= ms16(`SC_LEVEL_TRIG_MS)) begin
            tr_reg    <= sc_pkg::SC_TR_SCAN;
            tr_ms_reg <= 16'h0000;
          end else if (scan_trigger_n) begin
            tr_reg <= sc_pkg::SC_TR_IDLE;
          end
        end
        sc_pkg::SC_TR_SCAN: begin
          // decode, release or timeout ends level session
          // decode or timeout ends pulse session
          if (good_read || abort_cmd)
            tr_reg <= scan_trigger_n ? sc_pkg::SC_TR_IDLE : sc_pkg::SC_TR_REL;
          else if (!ctrl_reg[`SC_CTRL_PULSE] && scan_trigger_n)
            tr_reg <= sc_pkg::SC_TR_IDLE;
          else if (tr_ms_reg >= to_reg)
            tr_reg <= scan_trigger_n ? sc_pkg::SC_TR_IDLE : sc_pkg::SC_TR_REL;
        end
        sc_pkg::SC_TR_REL: begin
          if (scan_trigger_n)
            tr_reg <= sc_pkg::SC_TR_IDLE;
        end
        default: tr_reg <= sc_pkg::SC_TR_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Tone and LED
  // ****************************************************
  assign tone_pon = pon_pend_reg && ready && ctrl_reg[`SC_CTRL_PON_BEEP];
  assign tone_go  = tone_pon || (good_read && ctrl_reg[`SC_CTRL_GR_BEEP]);

  assign tif.start       = tone_go;
  assign tif.half_period = tone_pon ? PON_HP_CYC[15:0] : hp_reg;
  assign tif.dur_ms      = tone_pon ? ms16(`SC_PON_BEEP_MS) : dur_reg;
  assign tif.ms_tick     = tick_reg;

  sc_tone u_tone (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif.tone)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_on_reg <= 1'b0;
      led_ms_reg <= 16'h0000;
    end else if (good_read && ctrl_reg[`SC_CTRL_GR_LED]) begin
      led_on_reg <= (led_dur_reg != 16'h0000);
      led_ms_reg <= 16'h0000;
    end else if (led_on_reg && tick_reg) begin
      led_ms_reg <= led_ms_reg + 16'h0001;
      if (led_ms_reg + 16'h0001 >= led_dur_reg)
        led_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buzzer_out_n     <= 1'b0;
      buzzer_out_n_oe  <= 1'b0;
      read_ok_led_n    <= 1'b0;
      read_ok_led_n_oe <= 1'b0;
    end else begin
      buzzer_out_n     <= 1'b0;
      buzzer_out_n_oe  <= tif.pwm_low;
      read_ok_led_n    <= 1'b0;
      read_ok_led_n_oe <= led_on_reg;
    end
  end

  // ****************************************************
  // Interface routing
  // ****************************************************
  // select serial or USB
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iface_select <= 1'b0;
      fpc_usb_en   <= 1'b0;
      aux_usb_en   <= 1'b0;
      fpc_txd      <= 1'b0;
      fpc_rts_n    <= 1'b0;
      core_rxd     <= 1'b1;
      core_cts_n   <= 1'b1;
      cmd_ready    <= 1'b0;
      scan_active  <= 1'b0;
    end else begin
      iface_select <= ctrl_reg[`SC_CTRL_IFSEL];
      fpc_usb_en   <= ready && !ctrl_reg[`SC_CTRL_IFSEL];
      aux_usb_en   <= ready;
      fpc_txd      <= ready && ctrl_reg[`SC_CTRL_IFSEL] ? core_txd : 1'b0;
      fpc_rts_n    <= ready && ctrl_reg[`SC_CTRL_IFSEL] ? core_rts_n : 1'b0;
      core_rxd     <= ready && ctrl_reg[`SC_CTRL_IFSEL] ? fpc_rxd_dm : 1'b1;
      core_cts_n   <= ready && ctrl_reg[`SC_CTRL_IFSEL] ? fpc_cts_dp : 1'b1;
      cmd_ready    <= ready;
      scan_active  <= (tr_reg == sc_pkg::SC_TR_SCAN);
    end
  end

endmodule

// *** hdl/sc_pkg.sv ***
package sc_pkg;

  // Power-up sequence, Gray along the path
  typedef enum logic [1:0] {
    SC_PU_RESET = 2'b00,
    SC_PU_BOOT  = 2'b01,
    SC_PU_READY = 2'b11
  } sc_pu_t;

  // Trigger and decode session, Gray along the path except SCAN to IDLE
  typedef enum logic [1:0] {
    SC_TR_IDLE = 2'b00,
    SC_TR_LOW  = 2'b01,
    SC_TR_SCAN = 2'b11,
    SC_TR_REL  = 2'b10
  } sc_trig_t;

endpackage

// *** hdl/sc_tone.sv ***
`timescale 1ns/1ns
module sc_tone (
  input wire logic clk,
  input wire logic rst_n,
  sc_tone_if.tone  tif
);

  logic [15:0] hp_reg;
  logic [15:0] cyc_reg;
  logic [15:0] ms_reg;
  logic [15:0] dur_reg;
  logic        busy_reg;
  logic        low_reg;

  // Tone window: start loads, ends after dur_ms ticks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      ms_reg   <= 16'h0000;
      dur_reg  <= 16'h0000;
      hp_reg   <= 16'h0001;
    end else if (tif.start) begin
      busy_reg <= (tif.dur_ms != 16'h0000);
      ms_reg   <= 16'h0000;
      dur_reg  <= tif.dur_ms;
      hp_reg   <= (tif.half_period == 16'h0000) ? 16'h0001 : tif.half_period;
    end else if (busy_reg && tif.ms_tick) begin
      ms_reg <= ms_reg + 16'h0001;
      if (ms_reg + 16'h0001 >= dur_reg)
        busy_reg <= 1'b0;
    end
  end

  // Square wave, toggles every half period
  always_ff @(posedge clk) begin
    if (!rst_n || tif.start || !busy_reg) begin
      cyc_reg <= 16'h0000;
      low_reg <= 1'b1;
    end else if (cyc_reg + 16'h0001 >= hp_reg) begin
      cyc_reg <= 16'h0000;
      low_reg <= ~low_reg;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
    end
  end

  assign tif.busy    = busy_reg;
  assign tif.pwm_low = busy_reg & low_reg;

endmodule

// *** hdl/sc_tone_if.sv ***
`timescale 1ns/1ns
interface sc_tone_if;
  logic        start;
  logic [15:0] half_period;
  logic [15:0] dur_ms;
  logic        ms_tick;
  logic        busy;
  logic        pwm_low;

  modport src  (output start, output half_period, output dur_ms, output ms_tick,
                input busy, input pwm_low);
  modport tone (input start, input half_period, input dur_ms, input ms_tick,
                output busy, output pwm_low);
endinterface

// *** verif/sc_host_checker.sv ***
`timescale 1ns/1ns
// ****
// Checker on the top ports
// ****
module sc_host_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_txd,
  input wire logic        fpc_rxd_dm,
  input wire logic        core_rxd,
  input wire logic        fpc_txd,
  input wire logic        fpc_usb_en,
  input wire logic        aux_usb_en,
  input wire logic        iface_select,
  input wire logic        cmd_ready,
  input wire logic        scan_active,
  input wire logic        buzzer_out_n,
  input wire logic        buzzer_out_n_oe,
  input wire logic        read_ok_led_n,
  input wire logic        read_ok_led_n_oe
);
  localparam int EARLY = 969 * MS_CYCLES;
  localparam int LATE  = 971 * MS_CYCLES;
  logic [31:0] up_reg;

  // Cycles since reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_reg <= 32'h0;
    end else begin
      up_reg <= up_reg + 32'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ready_early: assert property (up_reg < EARLY |-> !cmd_ready)
    else $error("ready too early");
  chk_ready_late: assert property (up_reg > LATE |-> cmd_ready)
    else $error("ready too late");
  chk_pready_first: assert property (psel && !penable |=> pready)
    else $error("no zero-wait answer");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_bad_addr: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access not refused");
  chk_serial_tx: assert property ((cmd_ready && iface_select && $stable(core_txd))[*3]
    |-> fpc_txd == core_txd)
    else $error("transmit path wrong");
  chk_serial_rx: assert property ((cmd_ready && iface_select && $stable(fpc_rxd_dm))[*3]
    |-> core_rxd == fpc_rxd_dm)
    else $error("receive path wrong");
  chk_usb_mode: assert property ((cmd_ready && !iface_select)[*3]
    |-> fpc_usb_en && !fpc_txd)
    else $error("flat port not in usb mode");
  chk_aux_usb: assert property (cmd_ready[*2] |-> aux_usb_en)
    else $error("aux port not usb");
  chk_od_low: assert property (buzzer_out_n_oe || read_ok_led_n_oe
    |-> !buzzer_out_n && !read_ok_led_n)
    else $error("open drain drives high");
  chk_quiet_boot: assert property (!cmd_ready
    |-> !buzzer_out_n_oe && !read_ok_led_n_oe && !scan_active)
    else $error("activity before ready");
endmodule

bind sc_host_signals sc_host_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .core_txd, .fpc_rxd_dm,
  .core_rxd, .fpc_txd, .fpc_usb_en, .aux_usb_en, .iface_select, .cmd_ready,
  .scan_active, .buzzer_out_n, .buzzer_out_n_oe, .read_ok_led_n, .read_ok_led_n_oe
);

// *** verif/sc_host_model.sv ***
`timescale 1ns/1ns
// ****
// Host side: trigger and pulled-up pins
// ****
module sc_host_model (
  input wire logic clk,
  input wire logic trig_low,
  input wire logic od_clr,
  input wire logic buzz_n,
  input wire logic buzz_oe,
  input wire logic led_n,
  input wire logic led_oe,
  output logic     trig_n,
  output logic     buzz_pin,
  output logic     led_pin,
  output int       buzz_low,
  output int       led_low
);
  assign trig_n = !trig_low;
  assign buzz_pin = buzz_oe ? buzz_n : 1'b1;
  assign led_pin  = led_oe ? led_n : 1'b1;

  // Low-cycle counters per pin
  always @(posedge clk) begin
    buzz_low <= od_clr ? 0 : buzz_low + int'(!buzz_pin);
    led_low  <= od_clr ? 0 : led_low + int'(!led_pin);
  end
endmodule

// *** verif/sc_host_signals_bench.sv ***
`timescale 1ns/1ns
module sc_host_signals_bench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        core_txd, core_rts_n, core_rxd, core_cts_n, fpc_rxd_dm, fpc_cts_dp;
  logic        fpc_txd, fpc_rts_n, fpc_usb_en, aux_usb_en, iface_select, cmd_ready;
  logic        scan_active, scan_trigger_n, trig_low, od_clr;
  logic        buzzer_out_n_in, buzzer_out_n, buzzer_out_n_oe;
  logic        read_ok_led_n_in, read_ok_led_n, read_ok_led_n_oe;
  int          buzz_low, led_low, num_errors, tests_run, t0, up;

  sc_host_signals #(.MS_CYCLES(10), .PON_HP_CYC(3), .GR_HP_CYC(3)) dut_u (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .scan_trigger_n, .core_txd, .core_rts_n, .core_rxd, .core_cts_n,
    .fpc_rxd_dm, .fpc_cts_dp, .fpc_txd, .fpc_rts_n, .fpc_usb_en, .aux_usb_en,
    .iface_select, .cmd_ready, .scan_active, .buzzer_out_n_in, .buzzer_out_n,
    .buzzer_out_n_oe, .read_ok_led_n_in, .read_ok_led_n, .read_ok_led_n_oe);

  sc_host_model host_u (.clk, .trig_low, .od_clr, .buzz_n(buzzer_out_n),
    .buzz_oe(buzzer_out_n_oe), .led_n(read_ok_led_n), .led_oe(read_ok_led_n_oe),
    .trig_n(scan_trigger_n), .buzz_pin(buzzer_out_n_in), .led_pin(read_ok_led_n_in),
    .buzz_low, .led_low);

  // Clock and cycles since release
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) up <= rst_n ? up + 1 : 0;

  // ****
  // Tasks
  // ****
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string m);
    tests_run++;
    if (got < lo || got > hi) fail(m);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer, the watchdog bounds it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_scan(input logic v, input int lim);
    t0 = 0;
    while (scan_active !== v && t0 < lim) begin
      @(posedge clk);
      t0++;
    end
  endtask

  task automatic clr_cnt();
    od_clr <= 1'b1;
    @(posedge clk);
    od_clr <= 1'b0;
  endtask

  // Watchdog
  initial begin
    cyc(60000);
    fail("timeout");
    stop_test();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, trig_low} = '0;
    {core_txd, core_rts_n, fpc_rxd_dm, fpc_cts_dp, od_clr} = 5'h1F;
    cyc(2);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(12'h000, 32'h0000_000F, "ctrl reset");
    rdchk(12'h004, 32'h0000_0003, "tone period reset");
    rdchk(12'h008, 32'h0000_0050, "tone length reset");
    rdchk(12'h00C, 32'h0000_0014, "led length reset");
    rdchk(12'h010, 32'h0000_0BB8, "timeout reset");
    rdchk(12'h018, 32'h0000_0000, "status before ready");
    apb(1'b0, 12'h01C, 32'h0);
    chk(err, 1'b1, "unmapped not refused");
    trig_low <= 1'b1;
    cyc(150);
    chk(scan_active, 1'b0, "scan before ready");
    trig_low <= 1'b0;
    while (cmd_ready !== 1'b1) @(posedge clk);
    od_clr <= 1'b0;
    chk_rng(up, 9690, 9710, "ready time");
    cyc(4100);
    chk_rng(buzz_low, 1995, 2005, "power-on tone");
    chk(buzzer_out_n_oe, 1'b0, "buzzer not released");
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h008, 32'h5);
    apb(1'b1, 12'h00C, 32'h3);
    trig_low <= 1'b1;
    cyc(50);
    trig_low <= 1'b0;
    cyc(30);
    chk(scan_active, 1'b0, "short low started scan");
    trig_low <= 1'b1;
    wait_scan(1'b1, 300);
    chk_rng(t0, 101, 140, "level start time");
    clr_cnt();
    apb(1'b1, 12'h014, 32'h1);
    rdchk(12'h018, 32'h0000_0077, "status during good read");
    cyc(80);
    // Length is whole ms enables, so up to one ms short
    chk_rng(led_low, 21, 30, "led pulse");
    chk_rng(buzz_low, 23, 27, "good-read tone");
    chk(scan_active, 1'b0, "decode did not end");
    trig_low <= 1'b0;
    cyc(5);
    trig_low <= 1'b1;
    wait_scan(1'b1, 300);
    trig_low <= 1'b0;
    wait_scan(1'b0, 10);
    chk_rng(t0, 1, 9, "release end");
    apb(1'b1, 12'h000, 32'h13);
    clr_cnt();
    trig_low <= 1'b1;
    cyc(500);
    trig_low <= 1'b0;
    wait_scan(1'b1, 10);
    chk_rng(t0, 1, 9, "pulse start");
    cyc(100);
    chk(scan_active, 1'b1, "pulse scan stopped");
    apb(1'b1, 12'h014, 32'h1);
    cyc(60);
    chk_rng(buzz_low + led_low, 0, 0, "disabled indicators");
    chk(scan_active, 1'b0, "pulse decode end");
    trig_low <= 1'b1;
    cyc(150);
    trig_low <= 1'b0;
    wait_scan(1'b1, 10);
    apb(1'b1, 12'h014, 32'h2);
    wait_scan(1'b0, 10);
    chk_rng(t0, 1, 3, "abort end");
    apb(1'b1, 12'h010, 32'h2);
    trig_low <= 1'b1;
    cyc(150);
    trig_low <= 1'b0;
    wait_scan(1'b1, 10);
    wait_scan(1'b0, 60);
    chk_rng(t0, 10, 30, "session timeout");
    chk(iface_select, 1'b1, "serial selected");
    chk(fpc_txd, 1'b1, "serial tx idle");
    core_txd <= 1'b0;
    core_rts_n <= 1'b0;
    fpc_rxd_dm <= 1'b0;
    fpc_cts_dp <= 1'b0;
    cyc(4);
    chk(fpc_txd, 1'b0, "serial tx");
    chk(fpc_rts_n, 1'b0, "serial rts");
    chk(core_rxd, 1'b0, "serial rx");
    chk(core_cts_n, 1'b0, "serial cts");
    core_txd <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    cyc(4);
    chk(iface_select, 1'b0, "usb selected");
    chk(fpc_usb_en, 1'b1, "usb mode");
    chk(fpc_txd, 1'b0, "tx quiet in usb");
    chk(core_rxd, 1'b1, "rx released in usb");
    chk(aux_usb_en, 1'b1, "aux usb");
    // power removed for over 700 ms
    rst_n <= 1'b0;
    cyc(7010);
    chk(cmd_ready | fpc_usb_en | aux_usb_en | scan_active, 1'b0, "power-down levels");
    rst_n <= 1'b1;
    cyc(1);
    rdchk(12'h000, 32'h0000_000F, "ctrl after power cycle");
    apb(1'b1, 12'h000, 32'h0D);
    while (cmd_ready !== 1'b1) @(posedge clk);
    chk_rng(up, 9690, 9710, "ready after power cycle");
    clr_cnt();
    cyc(500);
    chk_rng(buzz_low, 0, 0, "power-on beep off");
    stop_test();
  end
endmodule
